// ---- rtl/accel_spi_params.svh ----
`ifndef ACCEL_SPI_PARAMS_SVH
`define ACCEL_SPI_PARAMS_SVH

// frame layout
`define FRAME_BITS      5'h10
`define CNT_MAX         5'h1F
`define RESP_SE_BIT     2
`define RESP_RE_BIT     1
`define RESP_DU_BIT     0
`define RESP_CNC_BIT    3
`define RESP_HE_BIT     2

// status and exception codes
`define ST_NONSENSOR    2'h3
`define ES_NONSENSOR    2'h2
`define ST_SENSOR       2'h1
`define ST_SELFTEST     2'h2
`define ST_EXCEPT       2'h0
`define ES_EXCEPT       2'h0

// control access opcodes
`define OPC_WRITE       2'h1
`define OPC_READ        2'h2

// output update modes
`define UPD_BOTH_ALL    2'h0
`define UPD_PER_AXIS    2'h1
`define UPD_BOTH_MSB    2'h2
`define UPD_CONTINUOUS  2'h3

// reset values: first response is error with request error and unavailable
`define RESP_POR        16'h0E03
`define CTRL_RESET      8'h00

// filter test timing and expected outputs
`define FILT_SETTLE_MS  60
`define CLK_FREQ_KHZ    200000
`define TEST_EXP_LO     14'h3400
`define TEST_EXP_MID    14'h0000
`define TEST_EXP_HI     14'h0C00
`define TEST_MID_TOL    14'h0001

`endif

// ---- rtl/accel_spi_pkg.sv ----
package accel_spi_pkg;

    // control register, bit 7 down to bit 0
    typedef struct packed {
        logic       power_down;
        logic       self_test_enable;
        logic       tempcomp_disable;
        logic [1:0] filter_test_select;
        logic       filter_reset;
        logic [1:0] output_update_mode;
    } ctrl_type;

    // 16-bit request as seen after the last serial bit
    typedef struct packed {
        logic [1:0] access_opcode;
        logic       sensor_read_select;
        logic [4:0] request_addr_field;
        logic [7:0] data;
    } req_type;

    typedef enum logic {
        FRM_IDLE,
        FRM_ACTIVE
    } frame_state_type;

endpackage

// ---- rtl/accel_spi_frame.sv ----
// What this block does
// [RULE1] request bit 13 high means sensor read, low means control access
// [RULE2] control opcode in bits 15:14: 01 writes, 10 reads the register
// [RULE3] address bits 12:8 ignored; all control accesses hit one register
// [RULE4] control write stores request bits 7:0 into the register
// [RULE5] sensor read: bits 15,14,12 form the sample sequence id
// [RULE6] sensor read: bits 1:0 select axis and byte; others ignored
// [RULE7] granted control response copies opcode into bits 14:13
// [RULE8] response bit 12 makes all sixteen bits odd parity
// [RULE9] non-sensor responses carry status 11 in bits 11:10
// [RULE10] non-sensor responses carry exception status 10 in bits 9:8
// [RULE11] control register readable; read returns it in bits 7:0
// [RULE12] rising clock edges per frame other than 16 set bit 2
// [RULE13] unknown requests set response bit 1
// [RULE14] first response after reset has request error and unavailable set
// [RULE15] sensor read flags power down and heater loop faults
// [RULE16] two control bits choose how output registers update
// [RULE17] filter reset bit holds both filters cleared, outputs zero
// [RULE18] filter test field selects normal input or 25/50/75% pattern
// [RULE19] test patterns settle within 60 ms to -3072, 0+-1, +3072
// [RULE20] one bit disables temperature compensation, one enables self-test
// [RULE21] power-down bit puts device in non-functional state
// [RULE22] control register clears to zero at power-up
// [RULE23] update modes 00, 01 and 10 freeze axes until the required bytes are read; mode 11 never freezes
// [RULE24] self-test active on sensor read returns status 10
// [RULE25] sensor data right justified in bits 9:0, zero padded
// [RULE26] each frame shifts out the response to the previous request
`timescale 1ns/10ps
`include "accel_spi_params.svh"

module accel_spi_frame #(
    parameter int unsigned SETTLE_CYC = `FILT_SETTLE_MS * `CLK_FREQ_KHZ
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  clk_en_i,
    input  wire logic                  sclk_i,
    input  wire logic                  select_n_i,
    input  wire logic                  mosi_i,
    input  wire logic [13:0]           x_data_i,
    input  wire logic [13:0]           y_data_i,
    input  wire logic                  heater_fault_i,
    output logic                       miso_o,
    output logic                       miso_oe_o,
    output accel_spi_pkg::ctrl_type    device_ctrl_o,
    output logic                       test_pattern_o,
    output logic                       test_settled_o,
    output logic                       test_match_o
);
    import accel_spi_pkg::*;

    // pin synchronisers; first stage feeds only the second
    logic sck_s1_r, sck_s2_r, sck_s3_r;
    logic sel_s1_r, sel_s2_r, sel_s3_r;
    logic mosi_s1_r, mosi_s2_r;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sck_s1_r  <= 1'b0;
            sck_s2_r  <= 1'b0;
            sck_s3_r  <= 1'b0;
            sel_s1_r  <= 1'b1;
            sel_s2_r  <= 1'b1;
            sel_s3_r  <= 1'b1;
            mosi_s1_r <= 1'b0;
            mosi_s2_r <= 1'b0;
        end else if (clk_en_i) begin
            sck_s1_r  <= sclk_i;
            sck_s2_r  <= sck_s1_r;
            sck_s3_r  <= sck_s2_r;
            sel_s1_r  <= select_n_i;
            sel_s2_r  <= sel_s1_r;
            sel_s3_r  <= sel_s2_r;
            mosi_s1_r <= mosi_i;
            mosi_s2_r <= mosi_s1_r;
        end
    end

    logic sck_rise, sck_fall, frame_start, frame_end;
    frame_state_type state_r, state_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt;
    logic        miso_r, miso_nxt, oe_r, oe_nxt;
    logic [15:0] resp_r, resp_nxt;
    ctrl_type    ctrl_r, ctrl_nxt;

    // edges seen by the system clock; link clock is slow against it
    assign sck_rise    = clk_en_i & sck_s2_r & ~sck_s3_r;
    assign sck_fall    = clk_en_i & ~sck_s2_r & sck_s3_r;
    assign frame_start = clk_en_i & ~sel_s2_r & sel_s3_r;
    assign frame_end   = clk_en_i & sel_s2_r & ~sel_s3_r
                         & (state_r == FRM_ACTIVE);

    // shifter: sample on rising sclk, launch next bit on falling sclk
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        rx_nxt    = rx_r;
        tx_nxt    = tx_r;
        if (frame_start) begin
            state_nxt = FRM_ACTIVE;
            cnt_nxt   = 5'h00;
            tx_nxt    = resp_r;                            // [RULE26]
        end else if (state_r == FRM_ACTIVE) begin
            if (sck_rise) begin
                rx_nxt = {rx_r[14:0], mosi_s2_r};
                if (cnt_r != `CNT_MAX)                      // [RULE12]
                    cnt_nxt = cnt_r + 5'h01;
            end
            if (sck_fall)
                tx_nxt = {tx_r[14:0], 1'b0};
            if (frame_end)
                state_nxt = FRM_IDLE;
        end
        miso_nxt = tx_nxt[15];
        oe_nxt   = (state_nxt == FRM_ACTIVE);
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= FRM_IDLE;
            cnt_r   <= 5'h00;
            rx_r    <= 16'h0000;
            tx_r    <= 16'h0000;
            miso_r  <= 1'b0;
            oe_r    <= 1'b0;
        end else if (clk_en_i) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            rx_r    <= rx_nxt;
            tx_r    <= tx_nxt;
            miso_r  <= miso_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // request decode
    req_type    req;
    logic       len_ok, sens_rd;
    logic [1:0] chan;
    logic [13:0] hold_x_r, hold_x_nxt, hold_y_r, hold_y_nxt;
    logic [9:0] sens_data;

    assign req     = req_type'(rx_r);
    assign len_ok  = (cnt_r == `FRAME_BITS);
    assign chan    = req.data[1:0];                        // [RULE6]
    assign sens_rd = frame_end & len_ok & req.sensor_read_select
                     & ~ctrl_r.power_down;

    // byte mux; lsb reads pad the upper six bits with zero
    always_comb begin
        unique case (chan)
            2'h0:    sens_data = {6'h00, hold_x_r[3:0]};    // [RULE25]
            2'h1:    sens_data = {6'h00, hold_y_r[3:0]};
            2'h2:    sens_data = hold_x_r[13:4];
            default: sens_data = hold_y_r[13:4];
        endcase
    end

    // response builder and control register
    always_comb begin
        logic [15:0] r;
        r        = 16'h0000;
        ctrl_nxt = ctrl_r;
        if (!len_ok) begin
            r[11:10]         = `ST_NONSENSOR;
            r[9:8]           = `ES_NONSENSOR;
            r[`RESP_SE_BIT]  = 1'b1;                        // [RULE12]
        end else if (req.sensor_read_select) begin          // [RULE1]
            r[15:13] = {req.request_addr_field[4],
                        req.access_opcode};                 // [RULE5]
            if (ctrl_r.power_down || heater_fault_i) begin
                r[11:10]           = `ST_EXCEPT;
                r[9:8]             = `ES_EXCEPT;
                r[`RESP_CNC_BIT]   = ctrl_r.power_down;     // [RULE15]
                r[`RESP_HE_BIT]    = heater_fault_i;        // [RULE15]
            end else begin
                if (ctrl_r.self_test_enable || ctrl_r.tempcomp_disable)
                    r[11:10] = `ST_SELFTEST;                // [RULE24]
                else
                    r[11:10] = `ST_SENSOR;
                r[9:0] = sens_data;                         // [RULE25]
            end
        end else begin
            // address field never looked at: one register only [RULE3]
            r[11:10] = `ST_NONSENSOR;                       // [RULE9]
            r[9:8]   = `ES_NONSENSOR;                       // [RULE10]
            unique case (req.access_opcode)                 // [RULE2]
                `OPC_WRITE: begin
                    r[14:13] = req.access_opcode;           // [RULE7]
                    r[7:0]   = req.data;
                    ctrl_nxt = ctrl_type'(req.data);        // [RULE4]
                end
                `OPC_READ: begin
                    r[14:13] = req.access_opcode;           // [RULE7]
                    r[7:0]   = ctrl_r;                      // [RULE11]
                end
                default: r[`RESP_RE_BIT] = 1'b1;            // [RULE13]
            endcase
        end
        r[12]    = ~^{r[15:13], r[11:0]};                   // [RULE8]
        resp_nxt = frame_end ? r : resp_r;
        if (!frame_end)
            ctrl_nxt = ctrl_r;
    end

    // reset values give the error first response and a clear register
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            resp_r <= `RESP_POR;                            // [RULE14]
            ctrl_r <= ctrl_type'(`CTRL_RESET);              // [RULE22]
        end else if (clk_en_i) begin
            resp_r <= resp_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    // output hold registers with read-driven freezing
    logic [1:0] frz_r, frz_nxt;
    logic [3:0] rd_r, rd_nxt;

    always_comb begin
        logic [3:0] m;
        logic [3:0] pair;
        m          = rd_r | (4'h1 << chan);
        pair       = 4'h5 << chan[0];
        frz_nxt    = frz_r;
        rd_nxt     = rd_r;
        if (ctrl_r.output_update_mode == `UPD_CONTINUOUS) begin
            frz_nxt = 2'h0;                                 // [RULE23]
            rd_nxt  = 4'h0;
        end else if (sens_rd) begin
            unique case (ctrl_r.output_update_mode)         // [RULE16]
                `UPD_BOTH_ALL: begin
                    frz_nxt = (m == 4'hF) ? 2'h0 : 2'h3;    // [RULE23]
                    rd_nxt  = (m == 4'hF) ? 4'h0 : m;
                end
                `UPD_PER_AXIS: begin
                    frz_nxt[chan[0]] = ((m & pair) != pair); // [RULE23]
                    rd_nxt = ((m & pair) == pair) ? (m & ~pair) : m;
                end
                default: begin
                    if (chan[1]) begin                      // [RULE23]
                        frz_nxt = (m[3:2] == 2'h3) ? 2'h0 : 2'h3;
                        rd_nxt  = (m[3:2] == 2'h3) ? 4'h0 : m;
                    end
                end
            endcase
        end
        // freeze taken this edge already blocks the update: no torn sample
        if (ctrl_r.filter_reset) begin
            hold_x_nxt = 14'h0000;                          // [RULE17]
            hold_y_nxt = 14'h0000;
        end else begin
            hold_x_nxt = frz_nxt[0] ? hold_x_r : x_data_i;
            hold_y_nxt = frz_nxt[1] ? hold_y_r : y_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frz_r    <= 2'h0;
            rd_r     <= 4'h0;
            hold_x_r <= 14'h0000;
            hold_y_r <= 14'h0000;
        end else if (clk_en_i) begin
            frz_r    <= frz_nxt;
            rd_r     <= rd_nxt;
            hold_x_r <= hold_x_nxt;
            hold_y_r <= hold_y_nxt;
        end
    end

    // filter test pattern, settle timer and expected value check
    logic [1:0]  pat_cnt_r, pat_cnt_nxt;
    logic        pat_r, pat_nxt, settled_r, settled_nxt;
    logic        match_r, match_nxt;
    logic [1:0]  ftst_prev_r;
    logic [23:0] settle_r, settle_nxt;
    logic [13:0] exp_val;

    always_comb begin
        pat_cnt_nxt = pat_cnt_r + 2'h1;
        // density in quarters equals the field value   [RULE18]
        pat_nxt     = (pat_cnt_r < ctrl_r.filter_test_select)
                      & ~ctrl_r.power_down;                 // [RULE21]
        settle_nxt  = settle_r;
        settled_nxt = settled_r;
        if (ctrl_r.filter_test_select == 2'h0 || ctrl_r.filter_reset
            || ctrl_r.filter_test_select != ftst_prev_r) begin
            settle_nxt  = 24'h000000;
            settled_nxt = 1'b0;
        end else if (settle_r >= 24'(SETTLE_CYC - 1)) begin
            settled_nxt = 1'b1;                             // [RULE19]
        end else begin
            settle_nxt  = settle_r + 24'h000001;
        end
        unique case (ctrl_r.filter_test_select)
            2'h1:    exp_val = `TEST_EXP_LO;
            2'h3:    exp_val = `TEST_EXP_HI;
            default: exp_val = `TEST_EXP_MID;
        endcase
        // mid density allows one count either side of zero
        if (ctrl_r.filter_test_select == 2'h2)
            match_nxt = settled_r
                && (hold_x_r + `TEST_MID_TOL <= 14'h0002)
                && (hold_y_r + `TEST_MID_TOL <= 14'h0002);  // [RULE19]
        else
            match_nxt = settled_r && hold_x_r == exp_val
                        && hold_y_r == exp_val;             // [RULE19]
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pat_cnt_r   <= 2'h0;
            pat_r       <= 1'b0;
            settle_r    <= 24'h000000;
            settled_r   <= 1'b0;
            match_r     <= 1'b0;
            ftst_prev_r <= 2'h0;
        end else if (clk_en_i) begin
            pat_cnt_r   <= pat_cnt_nxt;
            pat_r       <= pat_nxt;
            settle_r    <= settle_nxt;
            settled_r   <= settled_nxt;
            match_r     <= match_nxt;
            ftst_prev_r <= ctrl_r.filter_test_select;
        end
    end

    // all outputs straight from flops; control bits drive the analog side
    assign miso_o         = miso_r;
    assign miso_oe_o      = oe_r;
    assign device_ctrl_o  = ctrl_r;                        // [RULE20]
    assign test_pattern_o = pat_r;
    assign test_settled_o = settled_r;
    assign test_match_o   = match_r;

    // checks
    logic first_r;
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i)
            first_r <= 1'b1;
        else if (frame_start)
            first_r <= 1'b0;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    property p_parity;
        ^resp_r == 1'b1;
    endproperty
    a_parity: assert property (p_parity)                   // [RULE8]
        else $error("response parity not odd");

    property p_len_err;
        frame_end && !len_ok |=> resp_r[`RESP_SE_BIT]
            && resp_r[11:10] == `ST_NONSENSOR;
    endproperty
    a_len_err: assert property (p_len_err)                 // [RULE12]
        else $error("frame length error not flagged");

    property p_write;
        frame_end && len_ok && !req.sensor_read_select
            && req.access_opcode == `OPC_WRITE
            |=> ctrl_r == $past(rx_r[7:0]) && resp_r[14:13] == `OPC_WRITE;
    endproperty
    a_write: assert property (p_write)                     // [RULE4]
        else $error("control write not stored");

    property p_read;
        frame_end && len_ok && !req.sensor_read_select
            && req.access_opcode == `OPC_READ
            |=> resp_r[7:0] == $past(ctrl_r) && resp_r[9:8] == `ES_NONSENSOR;
    endproperty
    a_read: assert property (p_read)                       // [RULE11]
        else $error("control read data wrong");

    property p_req_err;
        frame_end && len_ok && !req.sensor_read_select
            && (req.access_opcode == 2'h0 || req.access_opcode == 2'h3)
            |=> resp_r[`RESP_RE_BIT] && resp_r[14:13] == 2'h0;
    endproperty
    a_req_err: assert property (p_req_err)                 // [RULE13]
        else $error("unknown request not flagged");

    property p_first;
        first_r && frame_start |=> tx_r == `RESP_POR;
    endproperty
    a_first: assert property (p_first)                     // [RULE14]
        else $error("first response not the error response");

    property p_cnc;
        frame_end && len_ok && req.sensor_read_select && ctrl_r.power_down
            |=> resp_r[`RESP_CNC_BIT] && resp_r[11:10] == `ST_EXCEPT;
    endproperty
    a_cnc: assert property (p_cnc)                         // [RULE15]
        else $error("power down read not flagged");

    property p_filt_zero;
        clk_en_i && ctrl_r.filter_reset ##1 clk_en_i && ctrl_r.filter_reset
            |-> hold_x_r == 14'h0000 && hold_y_r == 14'h0000;
    endproperty
    a_filt_zero: assert property (p_filt_zero)             // [RULE17]
        else $error("outputs not zero in filter reset");

    property p_selftest;
        frame_end && len_ok && req.sensor_read_select && !heater_fault_i
            && !ctrl_r.power_down && ctrl_r.self_test_enable
            |=> resp_r[11:10] == `ST_SELFTEST;
    endproperty
    a_selftest: assert property (p_selftest)               // [RULE24]
        else $error("self-test status missing");

    property p_load;
        frame_start |=> tx_r == $past(resp_r) && miso_oe_o;
    endproperty
    a_load: assert property (p_load)                       // [RULE26]
        else $error("previous response not loaded");

    c_write: cover property (frame_end && len_ok && !req.sensor_read_select
                             && req.access_opcode == `OPC_WRITE);
    c_sensor: cover property (sens_rd);
    c_len_err: cover property (frame_end && !len_ok);
    c_frozen: cover property (frz_r == 2'h3);

endmodule

// ---- dv/spi_master_model.sv ----
`timescale 1ns/10ps
module spi_master_model (
    input  wire logic clk_sys_i,
    input  wire logic miso_i,
    output logic      sclk_o,
    output logic      select_n_o,
    output logic      mosi_o
);
    // 80 ns half period at the 5 ns system clock
    localparam int HALF = 16;

    // mode 0 idle: clock parked low, select high
    initial begin
        sclk_o = 1'b0;
        select_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // one frame; resp is what the device shifts out, i.e. the answer
    // to the previous request, so a trailing frame collects the last
    task automatic xfer(input  logic [15:0] req,
                        input  int          nbits,
                        output logic [15:0] resp);
        logic [16:0] word;
        word = {req, 1'b0};
        resp = 16'h0000;
        @(posedge clk_sys_i);
        select_n_o <= 1'b0;
        wait_clk(HALF);
        for (int b = 0; b < nbits; b++) begin
            // msb first: opcode, sensor select, address, data
            mosi_o <= word[16 - b];
            wait_clk(HALF);
            if (b < 16) begin
                resp[15 - b] = miso_i;
            end
            sclk_o <= 1'b1; // each rise counted by the device
            wait_clk(HALF);
            sclk_o <= 1'b0;
        end
        wait_clk(HALF);
        select_n_o <= 1'b1;
        // idle data line must not look like a held bit
        mosi_o <= ~mosi_o;
        wait_clk(HALF);
    endtask
endmodule

// ---- dv/accel_spi_frame_and_control_test.sv ----
`timescale 1ns/10ps
module accel_spi_frame_and_control_test;
    import accel_spi_pkg::*;
    localparam int STEPS = 23;

    logic        clk_sys_i      = 1'b0;
    logic        rst_b_i        = 1'b0;
    logic [13:0] x_data_i       = 14'h0C80;
    logic [13:0] y_data_i       = 14'h3ABC;
    logic        heater_fault_i = 1'b0;
    logic        sclk;
    logic        select_n;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    ctrl_type    device_ctrl;
    logic        test_pattern;
    logic        test_settled;
    logic        test_match;
    int          n_mismatch     = 0;
    int          checks_done    = 0;
    int unsigned cycles         = 0;
    logic [15:0] resp;
    logic [15:0] pexp;
    logic [15:0] pmask;
    logic [15:0] cnt;

    // request, expected answer to it, and which answer bits are defined
    logic [15:0] req_t [STEPS] = '{16'h8000, 16'h5F5B, 16'h8A00, 16'h0000,
        16'hC0FF, 16'h5F00, 16'h5F00, 16'h4003, 16'h7FFE, 16'h2001,
        16'h4043, 16'h2000, 16'h4083, 16'h2002, 16'h4003, 16'h2003,
        16'h4007, 16'h2002, 16'h400B, 16'h4008, 16'h2002, 16'h2002,
        16'h8000};
    logic [15:0] exp_t [STEPS] = '{16'h4E00, 16'h2E5B, 16'h4E5B, 16'h0E02,
        16'h0E02, 16'h0E04, 16'h0E04, 16'h2E03, 16'hA4C8, 16'h040C,
        16'h2E43, 16'h0800, 16'h2E83, 16'h0008, 16'h2E03, 16'h0004,
        16'h2E07, 16'h0400, 16'h2E0B, 16'h2E08, 16'h0740, 16'h0740,
        16'h4E08};
    logic [15:0] mask_t [STEPS] = '{16'h6FFF, 16'h6FFF, 16'h6FFF, 16'h6FFF,
        16'h6FFF, 16'h0F04, 16'h0F04, 16'h6FFF, 16'hEFFF, 16'hEFFF,
        16'h6FFF, 16'hEFFF, 16'h6FFF, 16'h0F0C, 16'h6FFF, 16'h0F0C,
        16'h6FFF, 16'hEFFF, 16'h6FFF, 16'h6FFF, 16'hEFFF, 16'hEFFF,
        16'h6FFF};

    always #2.5 clk_sys_i = ~clk_sys_i;

    // short settle count keeps the filter test run brief
    accel_spi_frame #(.SETTLE_CYC(50)) DUT (
        .clk_sys_i      (clk_sys_i),
        .rst_b_i        (rst_b_i),
        .clk_en_i       (1'b1),
        .sclk_i         (sclk),
        .select_n_i     (select_n),
        .mosi_i         (mosi),
        .x_data_i       (x_data_i),
        .y_data_i       (y_data_i),
        .heater_fault_i (heater_fault_i),
        .miso_o         (miso),
        .miso_oe_o      (miso_oe),
        .device_ctrl_o  (device_ctrl),
        .test_pattern_o (test_pattern),
        .test_settled_o (test_settled),
        .test_match_o   (test_match)
    );

    spi_master_model master (
        .clk_sys_i  (clk_sys_i),
        .miso_i     (miso),
        .sclk_o     (sclk),
        .select_n_o (select_n),
        .mosi_o     (mosi)
    );

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] expd);
        checks_done = checks_done + 1;
        if (seen !== expd) begin
            $display("unexpected %s expected %h seen %h", what, expd, seen);
            n_mismatch = n_mismatch + 1;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard: about three times the expected run length
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch = n_mismatch + 1;
            results();
        end
    end

    // walk the request table, each answer judged one frame later
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check("ctrl", {8'h00, device_ctrl}, 16'h0000);
        pexp = 16'h0E03;
        pmask = 16'hFFFF;
        for (int i = 0; i < STEPS; i++) begin
            heater_fault_i <= (i == 15);
            if (i == 18) begin
                x_data_i <= 14'h3400;
                y_data_i <= 14'h3400;
            end
            // mode 00 froze both axes at step 20: new input must not show
            if (i == 21) begin
                x_data_i <= 14'h0C80;
            end
            master.xfer(req_t[i], (i == 5) ? 15 : (i == 6) ? 17 : 16, resp);
            check("resp", resp & pmask, pexp & pmask);
            check("parity", {15'h0000, ^resp}, 16'h0001);
            if (i == 22) begin
                check("frozen", resp & pmask, 16'h0740);
            end
            if (i == 1 || i == 6) begin
                check("ctrl", {8'h00, device_ctrl}, 16'h005B);
            end
            pexp = exp_t[i];
            pmask = mask_t[i];
            $display("step %0d done", i);
        end
        master.xfer(16'h8000, 16, resp);
        check("resp", resp & pmask, pexp & pmask);
        check("settled", {15'h0000, test_settled}, 16'h0001);
        check("match", {15'h0000, test_match}, 16'h0001);
        cnt = 16'h0000;
        repeat (8) begin
            @(posedge clk_sys_i);
            cnt = cnt + {15'h0000, test_pattern};
        end
        check("pattern", cnt, 16'h0002);
        $display("filter test done");
        results();
    end
endmodule
